//--- rtl/sidm_map.vh
// Purpose: constants for the safety I/O diagnostic monitor
// Assumes: 125 MHz mclk
// Notes: definitions only
`ifndef SIDM_MAP_VH
`define SIDM_MAP_VH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SIDM_CLK_MHZ 125
`define SIDM_PULSE_NS 1000
`define SIDM_PULSE_CYC ((`SIDM_PULSE_NS * `SIDM_CLK_MHZ) / 1000)
`define SIDM_SETTLE_NS 800
`define SIDM_SETTLE_CYC ((`SIDM_SETTLE_NS * `SIDM_CLK_MHZ + 999) / 1000)
`define SIDM_PERIOD_US 1000
`define SIDM_PERIOD_CYC (`SIDM_PERIOD_US * `SIDM_CLK_MHZ)
`define SIDM_TICK_US 1
`define SIDM_TICK_CYC (`SIDM_TICK_US * `SIDM_CLK_MHZ)
// ------------------------------------------------------------
// Feedback threshold: 0.3 V on a 12-bit, 3.3 V scale
// ------------------------------------------------------------
`define SIDM_ADC_W 12
`define SIDM_THRESH_MV 300
`define SIDM_ADC_FS_MV 3300
`define SIDM_THRESH_CODE ((`SIDM_THRESH_MV * 4095) / `SIDM_ADC_FS_MV)
// ------------------------------------------------------------
// Output function numbers and fault bit positions
// ------------------------------------------------------------
`define SIDM_FUNC_W 8
`define SIDM_FUNC_SSM 8'h0A
`define SIDM_DOF_ONE 0
`define SIDM_DOF_TWO 1
`define SIDM_DOF_FOUR 2
`define SIDM_DOF_FIVE 3
`define SIDM_NUM_DO 4
`define SIDM_NUM_DI 5
`define SIDM_DTIME_W 16
`endif

//--- rtl/sidm_sync2.v
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous to mclk
// Notes: first stage read only by the second
`timescale 1ns/1ns
module sidm_sync2 #(
    parameter W = 1
) (
    mclk,
    rst_n,
    asyncIn,
    syncOut
);
    input wire mclk;
    input wire rst_n;
    input wire [W-1:0] asyncIn;
    output reg [W-1:0] syncOut;
    reg [W-1:0] meta_reg;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            meta_reg <= asyncIn;
            syncOut <= meta_reg;
        end
    end
endmodule

//--- rtl/sidm_discrepancy.v
// Purpose: discrepancy timer and latched fault for one dual-channel input
// Assumes: channels already synchronised; tick is a one-cycle pulse
// Notes: limit counted in ticks
`timescale 1ns/1ns
`include "sidm_map.vh"
module sidm_discrepancy #(
    parameter TW = `SIDM_DTIME_W
) (
    mclk,
    rst_n,
    chanA,
    chanB,
    tick,
    limit,
    faultReset,
    fault
);
    input wire mclk;
    input wire rst_n;
    input wire chanA;
    input wire chanB;
    input wire tick;
    input wire [TW-1:0] limit;
    input wire faultReset;
    output reg fault;
    reg [TW-1:0] time_reg;
    wire differ;
    wire expired;

    assign differ = chanA ^ chanB;
    assign expired = differ && (time_reg > limit);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            time_reg <= {TW{1'b0}};
            fault <= 1'b0;
        end else begin
            if (!differ) begin
                time_reg <= {TW{1'b0}};
            end else if (tick && time_reg != {TW{1'b1}}) begin
                time_reg <= time_reg + {{(TW-1){1'b0}}, 1'b1};
            end
            // Set beats clear so a live fault is never lost
            if (expired) begin
                fault <= 1'b1;
            end else if (faultReset) begin
                fault <= 1'b0;
            end
        end
    end
endmodule

//--- rtl/sidm_monitor.v
// Purpose: safety I/O diagnostic monitor, output pulse test and input discrepancy
// Assumes: single mclk domain; feedback ADC codes are stable samples
// Notes: faults latch until faultReset
// Function
// RQ1: Pulse-test active output one, fault if feedback high
// RQ2: Pulse-test active output two, fault if feedback high
// RQ3: Pulse-test active output four, fault if feedback high
// RQ4: Pulse-test active output five, fault if feedback high
// RQ5: Shielded output skips pulse test and fault
// RQ6: Fault reset clears output fault; retest re-raises
// RQ7: Speed monitor on outputs three/six rejected
// RQ8: Input one discrepancy over limit raises fault
// RQ9: Input two discrepancy over limit raises fault
// RQ10: Input three discrepancy over limit raises fault
// RQ11: Input four discrepancy over limit raises fault
// RQ12: Wiring keeps channel mismatch within limit
// RQ13: Input five discrepancy over limit raises fault
// RQ14: Report config fault for misplaced speed monitor
// RQ15: Timer starts on mismatch, restarts on agreement
// RQ16: Faults stay latched until fault reset
`timescale 1ns/1ns
`include "sidm_map.vh"
module sidm_monitor #(
    parameter PERIOD_CYC = `SIDM_PERIOD_CYC,
    parameter TW = `SIDM_DTIME_W,
    parameter AW = `SIDM_ADC_W
) (
    mclk,
    rst_n,
    safeOutReq,
    safeOutShield,
    safeOutFeedback,
    plainOutThreeFunc,
    plainOutSixFunc,
    safeInChanA,
    safeInChanB,
    discrepancyTimeIn1,
    discrepancyTimeIn2,
    discrepancyTimeIn3,
    discrepancyTimeIn4,
    discrepancyTimeIn5,
    faultReset,
    safeOutDrive,
    outFault,
    configFault,
    inFault,
    anyFault
);
    input wire mclk;
    input wire rst_n;
    // Bit order: one, two, four, five
    input wire [`SIDM_NUM_DO-1:0] safeOutReq;
    input wire [`SIDM_NUM_DO-1:0] safeOutShield;
    input wire [`SIDM_NUM_DO*AW-1:0] safeOutFeedback;
    input wire [`SIDM_FUNC_W-1:0] plainOutThreeFunc;
    input wire [`SIDM_FUNC_W-1:0] plainOutSixFunc;
    // Bit order: input one at bit 0
    input wire [`SIDM_NUM_DI-1:0] safeInChanA;
    input wire [`SIDM_NUM_DI-1:0] safeInChanB;
    input wire [TW-1:0] discrepancyTimeIn1;
    input wire [TW-1:0] discrepancyTimeIn2;
    input wire [TW-1:0] discrepancyTimeIn3;
    input wire [TW-1:0] discrepancyTimeIn4;
    input wire [TW-1:0] discrepancyTimeIn5;
    input wire faultReset;
    output reg [`SIDM_NUM_DO-1:0] safeOutDrive;
    output reg [`SIDM_NUM_DO-1:0] outFault;
    output reg configFault;
    output reg [`SIDM_NUM_DI-1:0] inFault;
    output reg anyFault;

    // Scheduler states
    localparam ST_IDLE = 2'b00;
    localparam ST_PULSE = 2'b01;
    localparam ST_SAMPLE = 2'b10;
    // Counts in mclk cycles
    localparam [15:0] PULSE_CYC = `SIDM_PULSE_CYC;
    localparam [15:0] SETTLE_CYC = `SIDM_SETTLE_CYC;
    localparam [31:0] PERIOD_LAST = PERIOD_CYC - 1;
    localparam [15:0] TICK_LAST = `SIDM_TICK_CYC - 1;
    localparam [AW-1:0] THRESH = `SIDM_THRESH_CODE;

    // ------------------------------------------------------------
    // Synchronise field-side levels
    // ------------------------------------------------------------
    // Shield, feedback and function codes come from same-clock logic
    wire [`SIDM_NUM_DI-1:0] inA;
    wire [`SIDM_NUM_DI-1:0] inB;
    wire [`SIDM_NUM_DO-1:0] req;
    wire [`SIDM_NUM_DO-1:0] fbHigh;

    sidm_sync2 #(.W(`SIDM_NUM_DI)) u_syncA (
        .mclk(mclk),
        .rst_n(rst_n),
        .asyncIn(safeInChanA),
        .syncOut(inA)
    );
    sidm_sync2 #(.W(`SIDM_NUM_DI)) u_syncB (
        .mclk(mclk),
        .rst_n(rst_n),
        .asyncIn(safeInChanB),
        .syncOut(inB)
    );
    sidm_sync2 #(.W(`SIDM_NUM_DO)) u_syncReq (
        .mclk(mclk),
        .rst_n(rst_n),
        .asyncIn(safeOutReq),
        .syncOut(req)
    );

    // Not below threshold counts as failure, so equal also fails
    function notBelow;
        input [AW-1:0] code;
        begin
            notBelow = (code >= THRESH);
        end
    endfunction

    // Speed monitor is a safety function, plain outputs may not carry it
    function isSpeedMonitor;
        input [`SIDM_FUNC_W-1:0] func;
        begin
            isSpeedMonitor = (func == `SIDM_FUNC_SSM);
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < `SIDM_NUM_DO; g = g + 1) begin : g_fb
            assign fbHigh[g] = notBelow(safeOutFeedback[g*AW +: AW]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Test pulse scheduler
    // ------------------------------------------------------------
    reg [1:0] state_reg;
    reg [31:0] period_reg;
    reg [15:0] step_reg;
    reg [`SIDM_NUM_DO-1:0] testSel_reg;
    reg [`SIDM_NUM_DO-1:0] fail_reg;
    wire [`SIDM_NUM_DO-1:0] eligible;

    assign eligible = req & ~safeOutShield; // [RQ5]

    wire periodEnd;
    wire pulseDone;
    wire settleDone;
    reg [1:0] state_next;

    assign periodEnd = (period_reg == PERIOD_LAST);
    assign pulseDone = (step_reg == PULSE_CYC - 16'h1);
    assign settleDone = (step_reg == SETTLE_CYC - 16'h1);

    // ------------------------------------------------------------
    // Next-state decode
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (periodEnd && eligible != {`SIDM_NUM_DO{1'b0}}) begin
                    state_next = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (pulseDone) begin
                    state_next = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (settleDone) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            period_reg <= 32'h0000_0000;
            step_reg <= 16'h0000;
            testSel_reg <= {`SIDM_NUM_DO{1'b0}};
            fail_reg <= {`SIDM_NUM_DO{1'b0}};
        end else begin
            fail_reg <= {`SIDM_NUM_DO{1'b0}};
            period_reg <= periodEnd ? 32'h0000_0000 : period_reg + 32'h1;
            state_reg <= state_next;
            case (state_reg)
                ST_IDLE: begin
                    if (state_next == ST_PULSE) begin
                        testSel_reg <= eligible;
                        step_reg <= 16'h0000;
                    end
                end
                ST_PULSE: begin
                    step_reg <= pulseDone ? 16'h0000 : step_reg + 16'h1;
                end
                ST_SAMPLE: begin
                    // Wait for the switched-off output to decay before sampling
                    step_reg <= step_reg + 16'h1;
                    if (settleDone) begin
                        fail_reg <= testSel_reg & eligible & fbHigh; // [RQ1] [RQ2] [RQ3] [RQ4]
                        testSel_reg <= {`SIDM_NUM_DO{1'b0}};
                    end
                end
                default: begin
                    step_reg <= 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output drive and latched output faults
    // ------------------------------------------------------------
    wire testing;
    wire [`SIDM_NUM_DO-1:0] testMask;
    assign testing = (state_reg != ST_IDLE);
    assign testMask = testing ? testSel_reg : {`SIDM_NUM_DO{1'b0}};

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            safeOutDrive <= {`SIDM_NUM_DO{1'b0}};
            outFault <= {`SIDM_NUM_DO{1'b0}};
        end else begin
            // Pulse is a short off-gap on the active output
            safeOutDrive <= req & ~testMask; // [RQ1]
            // Set wins over reset, so a failing retest re-raises
            outFault <= fail_reg | (faultReset ? {`SIDM_NUM_DO{1'b0}} : outFault); // [RQ6] [RQ16]
        end
    end

    // ------------------------------------------------------------
    // Speed monitor placement check
    // ------------------------------------------------------------
    wire badAssign;
    assign badAssign = isSpeedMonitor(plainOutThreeFunc) ||
                       isSpeedMonitor(plainOutSixFunc); // [RQ7]

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            configFault <= 1'b0;
        end else if (badAssign) begin
            configFault <= 1'b1; // [RQ14]
        end else if (faultReset) begin
            configFault <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Discrepancy timebase and per-input checkers
    // ------------------------------------------------------------
    reg [15:0] tick_cnt_reg;
    reg tick_reg;
    wire tickEnd;
    wire [`SIDM_NUM_DI-1:0] discFault;
    wire [`SIDM_NUM_DI*TW-1:0] limits;

    assign limits = {discrepancyTimeIn5, discrepancyTimeIn4, discrepancyTimeIn3,
                     discrepancyTimeIn2, discrepancyTimeIn1};
    assign tickEnd = (tick_cnt_reg == TICK_LAST);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tickEnd;
            tick_cnt_reg <= tickEnd ? 16'h0000 : tick_cnt_reg + 16'h1;
        end
    end

    // Relies on the wiring keeping mismatch short in normal use [RQ12]
    generate
        for (g = 0; g < `SIDM_NUM_DI; g = g + 1) begin : g_disc
            sidm_discrepancy #(.TW(TW)) u_disc (
                .mclk(mclk),
                .rst_n(rst_n),
                .chanA(inA[g]),
                .chanB(inB[g]),
                .tick(tick_reg),
                .limit(limits[g*TW +: TW]),
                .faultReset(faultReset),
                .fault(discFault[g])
            ); // [RQ8] [RQ9] [RQ10] [RQ11] [RQ13] [RQ15]
        end
    endgenerate

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inFault <= {`SIDM_NUM_DI{1'b0}};
            anyFault <= 1'b0;
        end else begin
            inFault <= discFault; // [RQ16]
            // Built from the fault outputs so the summary lags all of them equally
            anyFault <= (|inFault) | (|outFault) | configFault;
        end
    end
endmodule

//--- bench/sidm_field_model.sv
// Purpose: field wiring model, safe input contacts and output loads
// Assumes: feedback is read as 12-bit ADC codes
// Notes: leak and skew are commanded by the bench only
`timescale 1ns/1ns
module sidm_field_model (
    input wire [3:0] safeOutDrive,
    input wire [3:0] leak,
    input wire [4:0] inLevel,
    input wire [4:0] inSkew,
    output wire [47:0] safeOutFeedback,
    output wire [4:0] chanA,
    output wire [4:0] chanB
);
    genvar g;
    // ------------------------------------------------------------
    // Output loads
    // ------------------------------------------------------------
    generate
        for (g = 0; g < 4; g = g + 1) begin : gLoad
            // Codes sit at and just below the threshold to catch an off-by-one compare
            assign safeOutFeedback[g*12 +: 12] = safeOutDrive[g] ? 12'hFFF :
                (leak[g] ? 12'h174 : 12'h173);
        end
    endgenerate
    // ------------------------------------------------------------
    // Dual-channel contacts
    // ------------------------------------------------------------
    assign chanA = inLevel;
    assign chanB = inLevel ^ inSkew;
endmodule

//--- bench/sidm_monitor_sva.sv
// Purpose: port-level checker for the diagnostic monitor
// Assumes: single mclk domain
// Notes: input one timer is mirrored in helper logic
`timescale 1ns/1ns
`include "sidm_map.vh"
module sidm_monitor_sva #(
    parameter PERIOD_CYC = 500,
    parameter TW = 16,
    parameter AW = 12
) (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] safeOutReq,
    input wire [3:0] safeOutShield,
    input wire [4*AW-1:0] safeOutFeedback,
    input wire [7:0] plainOutThreeFunc,
    input wire [7:0] plainOutSixFunc,
    input wire [4:0] safeInChanA,
    input wire [4:0] safeInChanB,
    input wire [TW-1:0] discrepancyTimeIn1,
    input wire [TW-1:0] discrepancyTimeIn2,
    input wire [TW-1:0] discrepancyTimeIn3,
    input wire [TW-1:0] discrepancyTimeIn4,
    input wire [TW-1:0] discrepancyTimeIn5,
    input wire faultReset,
    input wire [3:0] safeOutDrive,
    input wire [3:0] outFault,
    input wire configFault,
    input wire [4:0] inFault,
    input wire anyFault
);
    reg [23:0] misCnt_reg;
    reg [23:0] runHold_reg;
    reg [7:0] sinceLow_reg;
    wire mis0 = safeInChanA[0] ^ safeInChanB[0];
    wire [9:0] allFault = {outFault, inFault, configFault};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            misCnt_reg <= 24'h000000;
            runHold_reg <= 24'h000000;
            sinceLow_reg <= 8'hFF;
        end else begin
            misCnt_reg <= mis0 ? ((&misCnt_reg) ? misCnt_reg : misCnt_reg + 24'h000001) : 24'h000000;
            if (!mis0 && misCnt_reg != 24'h000000) begin
                runHold_reg <= misCnt_reg;
            end
            sinceLow_reg <= !safeOutDrive[0] ? 8'h00 :
                ((&sinceLow_reg) ? sinceLow_reg : sinceLow_reg + 8'h01);
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_pulse_low_run: assert property ($fell(safeOutDrive[0]) && safeOutReq[0] && $past(safeOutReq[0], 4) |-> ##1 !safeOutDrive[0] [*8])
        else $error("test pulse on output one too short");
    a_fault_after_test: assert property ($rose(outFault[0]) |-> sinceLow_reg < 8'h08)
        else $error("output one fault without a test pulse");
    a_shield_no_fault: assert property ((outFault & ~$past(outFault) & safeOutShield & $past(safeOutShield, 4)) == 4'h0)
        else $error("shielded output raised a fault");
    a_faults_latched: assert property (|($past(allFault) & ~allFault) |-> $past(faultReset))
        else $error("fault cleared without fault reset");
    a_config_flagged: assert property (plainOutThreeFunc == 8'h0A || plainOutSixFunc == 8'h0A |-> ##[0:3] configFault)
        else $error("speed monitor on plain output not flagged");
    a_disc_not_early: assert property ($rose(inFault[0]) |-> misCnt_reg >= discrepancyTimeIn1 * 24'd125 || runHold_reg >= discrepancyTimeIn1 * 24'd125)
        else $error("input one fault before limit");
    a_disc_not_late: assert property (misCnt_reg == (discrepancyTimeIn1 + 24'd2) * 24'd125 + 24'd8 |-> inFault[0])
        else $error("input one fault missing after limit");
    a_any_fault_or: assert property (anyFault == $past(|allFault))
        else $error("summary fault differs from fault set");
endmodule
bind sidm_monitor sidm_monitor_sva #(.PERIOD_CYC(PERIOD_CYC), .TW(TW), .AW(AW)) uSva (
    .mclk(mclk), .rst_n(rst_n), .safeOutReq(safeOutReq), .safeOutShield(safeOutShield),
    .safeOutFeedback(safeOutFeedback), .plainOutThreeFunc(plainOutThreeFunc),
    .plainOutSixFunc(plainOutSixFunc), .safeInChanA(safeInChanA), .safeInChanB(safeInChanB),
    .discrepancyTimeIn1(discrepancyTimeIn1), .discrepancyTimeIn2(discrepancyTimeIn2),
    .discrepancyTimeIn3(discrepancyTimeIn3), .discrepancyTimeIn4(discrepancyTimeIn4),
    .discrepancyTimeIn5(discrepancyTimeIn5), .faultReset(faultReset),
    .safeOutDrive(safeOutDrive), .outFault(outFault), .configFault(configFault),
    .inFault(inFault), .anyFault(anyFault));

//--- bench/sidm_monitor_test.sv
// Purpose: self-checking bench for the diagnostic monitor
// Assumes: test period shortened to 500 cycles
// Notes: inputs change on the falling edge only
`timescale 1ns/1ns
module sidm_monitor_test;
    localparam PER = 500;
    localparam TK = 125;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg faultReset = 1'b0;
    reg [3:0] safeOutReq = 4'h0;
    reg [3:0] safeOutShield = 4'h0;
    reg [3:0] leak = 4'h0;
    reg [7:0] funcThree = 8'h00;
    reg [7:0] funcSix = 8'h00;
    reg [4:0] inLevel = 5'h00;
    reg [4:0] inSkew = 5'h00;
    reg [15:0] lim [0:4];
    wire [47:0] fb;
    wire [4:0] chA, chB, inFault;
    wire [3:0] drive, outFault;
    wire configFault, anyFault;
    integer failures = 0;
    integer compares = 0;
    integer i;
`define CHECK(nm, exp, got) begin compares = compares + 1; if ((got) !== (exp)) begin \
    failures = failures + 1; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
    always #4 mclk = ~mclk;
    sidm_field_model field (.safeOutDrive(drive), .leak(leak), .inLevel(inLevel),
        .inSkew(inSkew), .safeOutFeedback(fb), .chanA(chA), .chanB(chB));
    sidm_monitor #(.PERIOD_CYC(PER)) DUT (.mclk(mclk), .rst_n(rst_n), .safeOutReq(safeOutReq),
        .safeOutShield(safeOutShield), .safeOutFeedback(fb), .plainOutThreeFunc(funcThree),
        .plainOutSixFunc(funcSix), .safeInChanA(chA), .safeInChanB(chB),
        .discrepancyTimeIn1(lim[0]), .discrepancyTimeIn2(lim[1]), .discrepancyTimeIn3(lim[2]),
        .discrepancyTimeIn4(lim[3]), .discrepancyTimeIn5(lim[4]), .faultReset(faultReset),
        .safeOutDrive(drive), .outFault(outFault), .configFault(configFault),
        .inFault(inFault), .anyFault(anyFault));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task waitCyc(input integer n);
        begin
            repeat (n) @(negedge mclk);
        end
    endtask
    task pulseReset;
        begin
            faultReset = 1'b1;
            waitCyc(2);
            faultReset = 1'b0;
            waitCyc(3);
        end
    endtask
    task results;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #(8 * 40000);
        failures = failures + 1;
        $display("MISMATCH watchdog expected done seen timeout");
        results;
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        for (i = 0; i < 5; i = i + 1) lim[i] = 16'h0002 + i;
        waitCyc(16);
        rst_n = 1'b1;
        waitCyc(2);
        `CHECK("reset outputs", 15'h0000, {drive, outFault, configFault, inFault, anyFault})
        safeOutReq = 4'hF;
        waitCyc(2 * PER + 300);
        `CHECK("clean outputs", 4'h0, outFault)
        `CHECK("drive follows request", 4'hF, drive)
        leak = 4'hF;
        safeOutShield = 4'h8;
        waitCyc(250);
        `CHECK("pulse gap", 4'h8, drive)
        waitCyc(PER + 50);
        `CHECK("leak faults", 4'h7, outFault)
        leak = 4'h0;
        waitCyc(PER + 300);
        `CHECK("leak latched", 4'h7, outFault)
        `CHECK("summary fault", 1'b1, anyFault)
        pulseReset;
        `CHECK("fault cleared", 4'h0, outFault)
        leak = 4'hF;
        safeOutShield = 4'h0;
        waitCyc(PER + 300);
        `CHECK("fault re-raised", 4'hF, outFault)
        safeOutReq = 4'h0;
        pulseReset;
        waitCyc(PER + 300);
        `CHECK("inactive untested", 4'h0, outFault)
        leak = 4'h0;
        $display("output pulse test done");
        for (i = 0; i < 3; i = i + 1) begin
            funcThree = (i == 0) ? 8'h0A : 8'h09;
            funcSix = (i == 1) ? 8'h0A : 8'h00;
            waitCyc(4);
            `CHECK("config fault", (i < 2) ? 1'b1 : 1'b0, configFault)
            funcThree = 8'h00;
            funcSix = 8'h00;
            pulseReset;
            `CHECK("config cleared", 1'b0, configFault)
        end
        $display("config test done");
        inLevel = 5'h1F;
        waitCyc(10);
        for (i = 0; i < 5; i = i + 1) begin
            inSkew = 5'h01 << i;
            waitCyc(lim[i] * TK - 150);
            inSkew = 5'h00;
            waitCyc(10);
            inSkew = 5'h01 << i;
            waitCyc(lim[i] * TK - 150);
            inSkew = 5'h00;
            waitCyc(10);
            `CHECK("short skew", 5'h00, inFault)
            inSkew = 5'h01 << i;
            waitCyc((lim[i] + 2) * TK + 20);
            inSkew = 5'h00;
            waitCyc(20);
            `CHECK("long skew", 5'h01 << i, inFault)
            pulseReset;
            `CHECK("skew cleared", 5'h00, inFault)
        end
        $display("discrepancy test done");
        results;
    end
endmodule
